// [design/pba_master.sv]
// Functional notes
// - Wanted grant is blocked and acked; else passed
// - Passed grant is never accepted afterwards
// - Take busy only after seeing it free
// - Single transfer drops request while ack held
// - Far-end terminator acks stray grants
// - Drop ack only after grant negation seen
// - Single transfer: busy and ack change together
// - Processor inhibits level grants while relevelling
// - Grants chained; requests, ack, busy shared lines
`timescale 1ns/1ps
`default_nettype none

module pba_master (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // User side
    input  wire logic       xfer_req_i,
    input  wire logic [2:0] level_i,
    input  wire logic       hold_i,
    input  wire logic       xfer_done_i,
    input  wire logic       term_mode_i,
    input  wire logic       proc_busy_i,
    output logic            master_o,
    output logic            bg_inhibit_o,
    output logic            select_ack_seen_o,
    output logic [4:0]      req_seen_o,
    // Grant chain
    input  wire logic [4:0] grant_in_i,
    output logic      [4:0] grant_out_o,
    // Shared request lines
    input  wire logic [4:0] req_i,
    output logic      [4:0] req_o,
    output logic      [4:0] req_oe_o,
    // Shared select_ack line
    input  wire logic       select_ack_i,
    output logic            select_ack_o,
    output logic            select_ack_oe_o,
    // Shared bus_busy_line
    input  wire logic       busy_i,
    output logic            busy_o,
    output logic            busy_oe_o
);

    // ============================================================
    // Input synchronisers
    logic [pba_pkg::SYNC_W-1:0] sync_vec;
    logic [4:0]                 gin_s;
    logic                       busy_s;

    pba_sync #(
        .W (pba_pkg::SYNC_W)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .async_i   ({req_i, select_ack_i, busy_i, grant_in_i}),
        .sync_o    (sync_vec)
    );

    assign gin_s  = sync_vec[4:0];
    assign busy_s = sync_vec[5];

    // ============================================================
    // State
    pba_pkg::pba_state_type state_reg, state_next;
    logic [2:0] lvl_reg,    lvl_next;
    logic       req_reg,    req_next;
    logic       select_ack_reg,   select_ack_next;
    logic       busy_reg,   busy_next;
    logic       tsack_reg,  tsack_next;
    logic       inh_reg,    inh_next;
    logic [4:0] gout_reg,   gout_next;
    logic [4:0] passed_reg, passed_next;
    logic [4:0] seen_reg,   seen_next;
    logic       ackin_reg,  ackin_next;

    logic [4:0] lvl_mask;
    logic [4:0] blk_mask;
    logic       my_gin;
    logic       my_passed;
    logic       accept;

    assign lvl_mask  = pba_pkg::LVL_ONE << lvl_reg;
    assign my_gin    = |(gin_s & lvl_mask);
    assign my_passed = |(passed_reg & lvl_mask);
    // A grant we already forwarded belongs to someone further down
    assign accept    = (state_reg == pba_pkg::ST_REQ) && my_gin && !my_passed;
    assign blk_mask  = (accept || state_reg == pba_pkg::ST_ACK) ? lvl_mask : pba_pkg::LINES_RST;

    // ============================================================
    // Next-state logic
    always_comb begin
        state_next  = state_reg;
        lvl_next    = lvl_reg;
        req_next    = req_reg;
        select_ack_next   = select_ack_reg;
        busy_next   = busy_reg;
        // Terminator acks any grant that reached the bus end
        tsack_next  = term_mode_i && (|gin_s);
        inh_next    = proc_busy_i;
        // Terminator is the chain end, so it forwards nothing
        gout_next   = term_mode_i ? pba_pkg::LINES_RST : (gin_s & ~blk_mask);
        passed_next = gin_s & (passed_reg | gout_next);
        seen_next   = sync_vec[11:7];
        ackin_next  = sync_vec[6];
        case (state_reg)
            pba_pkg::ST_IDLE: begin
                if (xfer_req_i && (level_i <= pba_pkg::LVL_BR4)) begin
                    lvl_next   = level_i;
                    req_next   = 1'b1;
                    state_next = pba_pkg::ST_REQ;
                end
            end
            pba_pkg::ST_REQ: begin
                if (accept) begin
                    select_ack_next  = 1'b1;
                    state_next = pba_pkg::ST_ACK;
                end
            end
            pba_pkg::ST_ACK: begin
                // Drop request while ack still up, unless more follows
                req_next = hold_i;
                if (!my_gin) begin
                    state_next = pba_pkg::ST_WAIT_BUSY;
                end
            end
            pba_pkg::ST_WAIT_BUSY: begin
                req_next = req_reg && hold_i;
                if (!busy_s) begin
                    busy_next  = 1'b1;
                    select_ack_next  = 1'b0;
                    state_next = pba_pkg::ST_MASTER;
                end
            end
            pba_pkg::ST_MASTER: begin
                if (xfer_done_i) begin
                    busy_next  = 1'b0;
                    state_next = req_reg ? pba_pkg::ST_REQ : pba_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = pba_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg  <= pba_pkg::ST_IDLE;
            lvl_reg    <= pba_pkg::LVL_NONPROC;
            req_reg    <= pba_pkg::BIT_RST;
            select_ack_reg   <= pba_pkg::BIT_RST;
            busy_reg   <= pba_pkg::BIT_RST;
            tsack_reg  <= pba_pkg::BIT_RST;
            inh_reg    <= pba_pkg::BIT_RST;
            gout_reg   <= pba_pkg::LINES_RST;
            passed_reg <= pba_pkg::LINES_RST;
            seen_reg   <= pba_pkg::LINES_RST;
            ackin_reg  <= pba_pkg::BIT_RST;
        end else begin
            state_reg  <= state_next;
            lvl_reg    <= lvl_next;
            req_reg    <= req_next;
            select_ack_reg   <= select_ack_next;
            busy_reg   <= busy_next;
            tsack_reg  <= tsack_next;
            inh_reg    <= inh_next;
            gout_reg   <= gout_next;
            passed_reg <= passed_next;
            seen_reg   <= seen_next;
            ackin_reg  <= ackin_next;
        end
    end

    // ============================================================
    // Outputs; shared lines are wired-OR, enable high when asserted
    assign master_o     = busy_reg;
    assign bg_inhibit_o = inh_reg;
    assign select_ack_seen_o  = ackin_reg;
    assign req_seen_o   = seen_reg;
    assign grant_out_o  = gout_reg;
    assign req_o        = {pba_pkg::NUM_LVL{pba_pkg::LINE_DRIVE}};
    assign req_oe_o     = req_reg ? lvl_mask : pba_pkg::LINES_RST;
    assign select_ack_o       = pba_pkg::LINE_DRIVE;
    assign select_ack_oe_o    = select_ack_reg || tsack_reg;
    assign busy_o       = pba_pkg::LINE_DRIVE;
    assign busy_oe_o    = busy_reg;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence s_accept;
        (state_reg == pba_pkg::ST_REQ) && my_gin && !my_passed;
    endsequence

    sequence s_take_bus;
        $rose(busy_reg) && $fell(select_ack_reg);
    endsequence

    property p_accept;
        s_accept |=> select_ack_reg && ((gout_reg & $past(lvl_mask)) == pba_pkg::LINES_RST);
    endproperty
    a_accept: assert property (p_accept) else $error("grant not blocked and acked");

    property p_pass;
        !term_mode_i |=> ((gout_reg | $past(blk_mask)) == ($past(gin_s) | $past(blk_mask)));
    endproperty
    a_pass: assert property (p_pass) else $error("grant chain not forwarded");

    property p_no_late_accept;
        $rose(select_ack_reg) |-> $past(state_reg == pba_pkg::ST_REQ) && !$past(my_passed);
    endproperty
    a_no_late_accept: assert property (p_no_late_accept) else $error("passed grant accepted");

    property p_busy_wait;
        $rose(busy_reg) |-> !$past(busy_s) && $past(state_reg == pba_pkg::ST_WAIT_BUSY);
    endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("busy taken while line busy");

    property p_req_until_ack;
        $rose(select_ack_reg) |-> req_reg ##1 (req_reg == $past(hold_i));
    endproperty
    a_req_until_ack: assert property (p_req_until_ack) else $error("request dropped early");

    property p_ack_interlock;
        $fell(select_ack_reg) |-> busy_reg && !$past(my_gin);
    endproperty
    a_ack_interlock: assert property (p_ack_interlock) else $error("ack dropped before grant negated");

    property p_busy_with_ack;
        $rose(busy_reg) |-> s_take_bus;
    endproperty
    a_busy_with_ack: assert property (p_busy_with_ack) else $error("busy and ack not together");

    property p_terminator;
        term_mode_i |=> (tsack_reg == $past(|gin_s)) && (gout_reg == pba_pkg::LINES_RST);
    endproperty
    a_terminator: assert property (p_terminator) else $error("terminator ack wrong");

    property p_inhibit;
        proc_busy_i ##1 proc_busy_i |-> bg_inhibit_o ##1 bg_inhibit_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit not followed");

endmodule : pba_master

`default_nettype wire

// [design/pba_pkg.sv]
package pba_pkg;

    // ============================================================
    // Grant and request line layout
    localparam int unsigned NUM_LVL     = 5;
    localparam logic [2:0]  LVL_NONPROC = 3'h0;
    localparam logic [2:0]  LVL_BR7     = 3'h1;
    localparam logic [2:0]  LVL_BR6     = 3'h2;
    localparam logic [2:0]  LVL_BR5     = 3'h3;
    localparam logic [2:0]  LVL_BR4     = 3'h4;
    localparam logic [4:0]  LVL_ONE     = 5'h01;

    // ============================================================
    // Synchroniser vector: grants in, busy, ack, requests
    localparam int unsigned SYNC_W      = 12;

    // ============================================================
    // Reset values and driven line level
    localparam logic [4:0]  LINES_RST   = 5'h00;
    localparam logic        BIT_RST     = 1'b0;
    localparam logic        LINE_DRIVE  = 1'b1;

    // ============================================================
    // Master sequence states
    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_REQ       = 3'h1,
        ST_ACK       = 3'h2,
        ST_WAIT_BUSY = 3'h3,
        ST_MASTER    = 3'h4
    } pba_state_type;

endpackage : pba_pkg

// [design/pba_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pba_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    // ============================================================
    // Two-stage synchroniser; first stage feeds only the second
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : pba_sync

`default_nettype wire

// [tb/pba_arb_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Central arbitrator model, cycle counters rounded up
module pba_arb_model #(
    parameter int HOLD = 8,
    parameter int TMO  = 500
) (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic [4:0] req_i,
    input  wire logic       select_ack_i,
    input  wire logic [2:0] proc_lvl_i,
    input  wire logic       inhibit_i,
    output logic      [4:0] grant_o
);
    int         hold_cnt;
    int         tmo_cnt;
    logic [4:0] pick;

    // Nonproc first, then levels 7..4 above processor level
    always_comb begin
        pick = 5'h00;
        for (int i = 4; i >= 1; i--) begin
            if (req_i[i] && !inhibit_i && (8 - i) > int'(proc_lvl_i)) begin
                pick = 5'h01 << i;
            end
        end
        if (req_i[0]) begin
            pick = 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            grant_o  <= 5'h00;
            hold_cnt <= 0;
            tmo_cnt  <= 0;
        end else if (select_ack_i) begin
            grant_o  <= 5'h00;
            hold_cnt <= 0;
        end else if (grant_o != 5'h00) begin
            tmo_cnt <= tmo_cnt + 1;
            if (tmo_cnt >= TMO) begin
                grant_o  <= 5'h00;
                hold_cnt <= 0;
            end
        end else if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1;
        end else begin
            tmo_cnt <= 0;
            grant_o <= pick;
        end
    end
endmodule : pba_arb_model

`default_nettype wire

// [tb/priority_bus_arbiter_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module priority_bus_arbiter_tb;
    logic       clk_sys_i, nrst_i, xfer_req, xfer_done, term_mode, proc_busy, other_busy;
    logic       master, bg_inh, select_ack_o, select_ack_oe, busy_o, busy_oe, hold, select_ack_seen;
    logic [2:0] level;
    logic [4:0] other_req, grant_in, grant_out, req_o, req_oe, req_seen;
    int         errors, n_checks, cyc, i, lvl;

    // ============================================================
    // Wired-OR shared lines, released lines fall to 0
    wire logic [4:0] req_w  = (req_o & req_oe) | other_req;
    wire logic       select_ack_w = select_ack_o & select_ack_oe;
    wire logic       busy_w = (busy_o & busy_oe) | other_busy;

    pba_master pba_master_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .xfer_req_i(xfer_req), .level_i(level),
        .hold_i(hold), .xfer_done_i(xfer_done), .term_mode_i(term_mode),
        .proc_busy_i(proc_busy), .master_o(master), .bg_inhibit_o(bg_inh),
        .select_ack_seen_o(select_ack_seen), .req_seen_o(req_seen),
        .grant_in_i(grant_in), .grant_out_o(grant_out),
        .req_i(req_w), .req_o(req_o), .req_oe_o(req_oe), .select_ack_i(select_ack_w), .select_ack_o(select_ack_o),
        .select_ack_oe_o(select_ack_oe), .busy_i(busy_w), .busy_o(busy_o), .busy_oe_o(busy_oe));

    pba_arb_model pba_arb_model_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_w), .select_ack_i(select_ack_w),
        .proc_lvl_i(3'h0), .inhibit_i(bg_inh), .grant_o(grant_in));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ============================================================
    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] lvl_bit(input int l);
        return 8'h01 << l;
    endfunction : lvl_bit

    task automatic start(input int l);
        @(negedge clk_sys_i);
        xfer_req = 1'b1;
        level    = 3'(l);
        @(negedge clk_sys_i);
        xfer_req = 1'b0;
    endtask : start

    task automatic finish(input int l);
        // Room for a whole grant timeout before the regrant
        for (i = 0; i < 1000 && !select_ack_oe; i++) @(negedge clk_sys_i);
        check({3'h0, grant_out}, 8'h00);
        for (i = 0; i < 20 && req_oe[l]; i++) @(negedge clk_sys_i);
        check({req_oe[l], select_ack_oe}, 8'h01);
        if (other_busy) begin
            // Old master still owns the data section
            repeat (30) @(negedge clk_sys_i);
            check({7'h00, busy_oe}, 8'h00);
            other_busy = 1'b0;
        end
        for (i = 0; i < 200 && !busy_oe; i++) @(negedge clk_sys_i);
        check({busy_oe, master, select_ack_oe, grant_in}, 8'hc0);
        check({7'h00, select_ack_seen}, 8'h01);
        xfer_done = 1'b1;
        @(negedge clk_sys_i);
        xfer_done = 1'b0;
        @(negedge clk_sys_i);
        check({busy_oe, master}, 8'h00);
    endtask : finish

    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    initial begin
        nrst_i     = 1'b0;
        xfer_req   = 1'b0;
        level      = 3'h0;
        xfer_done  = 1'b0;
        term_mode  = 1'b0;
        proc_busy  = 1'b0;
        other_req  = 5'h00;
        other_busy = 1'b0;
        hold       = 1'b0;
        i = $urandom(67);
        repeat (5) @(negedge clk_sys_i);
        check({master, select_ack_oe, busy_oe, req_oe}, 8'h00);
        nrst_i = 1'b1;
        // Every level once, then random levels; busy holders random throughout
        for (int k = 0; k < 12; k++) begin
            lvl = (k < 5) ? k : int'($urandom % 5);
            other_busy = 1'($urandom % 2);
            start(lvl);
            finish(lvl);
        end
        // Grant passed on while idle must not be taken back
        lvl = 1 + int'($urandom % 4);
        other_req = 5'h01 << lvl;
        for (i = 0; i < 100 && !grant_out[lvl]; i++) @(negedge clk_sys_i);
        check({3'h0, grant_out}, lvl_bit(lvl));
        other_req = 5'h00;
        start(lvl);
        repeat (10) @(negedge clk_sys_i);
        check({7'h00, select_ack_oe}, 8'h00);
        finish(lvl);
        // Held request outlives the first ack cycle
        hold = 1'b1;
        start(lvl);
        for (i = 0; i < 1000 && !select_ack_oe; i++) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        check({7'h00, req_oe[lvl]}, 8'h01);
        hold = 1'b0;
        finish(lvl);
        // Far-end terminator acks a stray grant
        term_mode = 1'b1;
        other_req = 5'h04;
        for (i = 0; i < 100 && !select_ack_oe; i++) @(negedge clk_sys_i);
        other_req = 5'h00;
        check({2'h0, select_ack_oe, grant_out}, 8'h20);
        check({2'h0, select_ack_seen, req_seen}, lvl_bit(2));
        for (i = 0; i < 20 && select_ack_oe; i++) @(negedge clk_sys_i);
        check({grant_in, select_ack_oe}, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        check({2'h0, select_ack_seen, req_seen}, 8'h00);
        term_mode = 1'b0;
        // Nonproc still served while level grants are held off
        proc_busy = 1'b1;
        @(negedge clk_sys_i);
        check({7'h00, bg_inh}, 8'h01);
        start(0);
        finish(0);
        proc_busy = 1'b0;
        results();
    end
endmodule : priority_bus_arbiter_tb

`default_nettype wire
